//--- logic/rtcb_bkp_if.sv
`timescale 1ns/100ps
interface rtcb_bkp_if;
  import rtcb_pkg::*;
  logic                we;
  logic [BKP_AW-1:0]   addr;
  logic [BKP_W-1:0]    wdata;
  logic [BKP_W-1:0]    rdata;
  modport master (output we, output addr, output wdata, input rdata);
  modport slave (input we, input addr, input wdata, output rdata);
endinterface

//--- logic/rtcb_bkp_mem.sv
`timescale 1ns/100ps
module rtcb_bkp_mem
(
  input  wire logic  clock,
  input  wire logic  bkp_rst,
  rtcb_bkp_if.slave  port
);
  import rtcb_pkg::*;
  logic [BKP_W-1:0] mem_r [BKP_N];
  // backup storage clears only on its own domain reset, not system reset
  always_ff @(posedge clock or posedge bkp_rst)
  begin
    if (bkp_rst)
    begin
      for (int i = 0; i < BKP_N; i++)
        mem_r[i] <= '0;
    end
    else if (port.we && int'(port.addr) < BKP_N)
      mem_r[port.addr] <= port.wdata;
  end
  always_ff @(posedge clock or posedge bkp_rst)
  begin
    if (bkp_rst)
      port.rdata <= '0;
    else if (int'(port.addr) < BKP_N)
      port.rdata <= mem_r[port.addr];
    else
      port.rdata <= '0;
  end
endmodule // rtcb_bkp_mem

//--- logic/rtcb_pkg.sv
package rtcb_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int CNT_W = 32;
  localparam int PRE_W = 20;
  localparam int BKP_N = 10;
  localparam int BKP_W = 16;
  localparam int BKP_AW = 4;
  // word indices; byte address = 4 * index
  localparam logic [ADDR_W-1:0] IDX_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] IDX_PRELOAD = 6'h01;
  localparam logic [ADDR_W-1:0] IDX_PREDIV = 6'h02;
  localparam logic [ADDR_W-1:0] IDX_COUNT = 6'h03;
  localparam logic [ADDR_W-1:0] IDX_ALARM = 6'h04;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 6'h05;
  localparam logic [ADDR_W-1:0] IDX_CLEAR = 6'h06;
  localparam logic [ADDR_W-1:0] IDX_IEN = 6'h07;
  localparam logic [ADDR_W-1:0] IDX_BKP0 = 6'h10;
  // ctrl fields
  localparam int CTRL_SRC_LO = 0;
  localparam int CTRL_SRC_HI = 1;
  localparam int CTRL_EN = 2;
  localparam int CTRL_CAL = 3;
  localparam int CTRL_W = 4;
  // status bits
  localparam int ST_SEC = 0;
  localparam int ST_ALR = 1;
  localparam int ST_OVF = 2;
  localparam int ST_W = 3;
  typedef enum logic [1:0] {
    RTCB_SRC_LSE  = 2'h0,
    RTCB_SRC_LSI  = 2'h1,
    RTCB_SRC_FASTD = 2'h2,
    RTCB_SRC_OFF  = 2'h3
  } rtcb_src_t;
  localparam logic [PRE_W-1:0] PRELOAD_RST = 20'h07FFF;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h4;
  localparam int FAST_DIV = 128;
  localparam int CAL_DIV = 64;
  localparam logic [DATA_W-1:0] RD_ZERO = 32'h00000000;
endpackage

//--- logic/rtcb_top.sv
// What this block does
// - counters run continuously; alarm and periodic interrupts offered to software
// - counter clock selectable: external 32.768 kHz, internal 40 kHz, fast osc/128
// - 32-bit counter compared to software alarm value; match asserts alarm
// - 20-bit prescaler makes tick; default gives one second from 32.768 kHz
// - 512 Hz calibration output derived from the clock source
// - ten 16-bit backup registers hold 20 bytes across main supply loss
// - clock logic keeps running in Stop and Standby
// - alarm drives one external event line to wake from Stop
// - alarm causes exit from Standby
// - backup contents survive Standby; ordinary registers are lost
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
module rtcb_top
#(
  parameter int PRE_WIDTH = rtcb_pkg::PRE_W
)
(
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                bkp_rst,
  input  wire logic                lse_tick,
  input  wire logic                lsi_tick,
  input  wire logic                fast_external_osc_tick,
  input  wire logic                low_power_state,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [rtcb_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [rtcb_pkg::DATA_W-1:0] wb_dat_i,
  output logic [rtcb_pkg::DATA_W-1:0]      wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     irq,
  output logic                     external_event_lines_alarm,
  output logic                     standby_wake,
  output logic                     cal_out
);
  import rtcb_pkg::*;

  logic [CTRL_W-1:0]    ctrl_r;
  logic [PRE_WIDTH-1:0] preload_r;
  logic [PRE_WIDTH-1:0] prediv_r;
  logic [CNT_W-1:0]     count_r;
  logic [CNT_W-1:0]     alarm_r;
  logic [ST_W-1:0]      status_r;
  logic [ST_W-1:0]      ien_r;
  logic [7:0]           fast_div_r;
  logic                 fast_tick_r;
  logic [6:0]           cal_div_r;
  logic                 src_tick;
  logic                 pre_ovf;
  logic                 alarm_hit;
  logic                 wr_acc;
  logic                 rd_acc;
  logic [ST_W-1:0]      clr_mask;
  logic [DATA_W-1:0]    rd_mux;
  logic                 bkp_sel;
  logic                 bkp_pend_r;
  rtcb_src_t            src;

  rtcb_bkp_if bkp ();

  rtcb_bkp_mem u_bkp (
    .clock   (clock),
    .bkp_rst (bkp_rst),
    .port    (bkp.slave)
  );

  assign src = rtcb_src_t'(ctrl_r[CTRL_SRC_HI:CTRL_SRC_LO]);

  // fast osc divided by 128
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fast_div_r  <= '0;
      fast_tick_r <= 1'b0;
    end
    else if (fast_external_osc_tick)
    begin
      fast_div_r  <= (fast_div_r == 8'(FAST_DIV - 1)) ? 8'h00 : fast_div_r + 8'h01;
      fast_tick_r <= (fast_div_r == 8'(FAST_DIV - 1));
    end
    else
      fast_tick_r <= 1'b0;
  end

  always_comb
  begin
    unique case (src)
      RTCB_SRC_LSE:  src_tick = lse_tick;
      RTCB_SRC_LSI:  src_tick = lsi_tick;
      RTCB_SRC_FASTD: src_tick = fast_tick_r;
      RTCB_SRC_OFF:  src_tick = 1'b0;
    endcase
  end

  // low_power_state deliberately not used for counting, only for standby_wake: time keeping never stops
  assign pre_ovf = ctrl_r[CTRL_EN] && src_tick && prediv_r == '0;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      prediv_r <= PRE_WIDTH'(PRELOAD_RST);
    else if (wr_acc && wb_adr_i == IDX_PRELOAD)
      prediv_r <= wb_dat_i[PRE_WIDTH-1:0];
    else if (ctrl_r[CTRL_EN] && src_tick)
      prediv_r <= (prediv_r == '0) ? preload_r : prediv_r - 1'b1;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      count_r <= '0;
    else if (wr_acc && wb_adr_i == IDX_COUNT)
      count_r <= wb_dat_i;
    else if (pre_ovf)
      count_r <= count_r + 1'b1;
  end

  assign alarm_hit = pre_ovf && (count_r + 1'b1 == alarm_r);

  // calibration: source / 32 toggled (period of 64 ticks) gives 512 Hz from 32.768 kHz
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cal_div_r <= '0;
      cal_out   <= 1'b0;
    end
    else if (!ctrl_r[CTRL_CAL])
    begin
      cal_div_r <= '0;
      cal_out   <= 1'b0;
    end
    else if (src_tick)
    begin
      cal_div_r <= (cal_div_r == 7'(CAL_DIV/2 - 1)) ? 7'h00 : cal_div_r + 7'h01;
      if (cal_div_r == 7'(CAL_DIV/2 - 1))
        cal_out <= ~cal_out;
    end
  end

  // bus
  assign wr_acc = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hF;
  assign rd_acc = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign bkp_sel = wb_adr_i >= IDX_BKP0 && wb_adr_i < IDX_BKP0 + 6'(BKP_N);
  assign clr_mask = (wr_acc && wb_adr_i == IDX_CLEAR) ? wb_dat_i[ST_W-1:0] : '0;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_r    <= CTRL_RST;
      preload_r <= PRE_WIDTH'(PRELOAD_RST);
      alarm_r   <= '1;
      ien_r     <= '0;
    end
    else if (wr_acc)
    begin
      if (wb_adr_i == IDX_CTRL)    ctrl_r    <= wb_dat_i[CTRL_W-1:0];
      if (wb_adr_i == IDX_PRELOAD) preload_r <= wb_dat_i[PRE_WIDTH-1:0];
      if (wb_adr_i == IDX_ALARM)   alarm_r   <= wb_dat_i;
      if (wb_adr_i == IDX_IEN)     ien_r     <= wb_dat_i[ST_W-1:0];
    end
  end

  // set wins over clear
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      status_r <= '0;
    else
    begin
      status_r[ST_SEC] <= pre_ovf | (status_r[ST_SEC] & ~clr_mask[ST_SEC]);
      status_r[ST_ALR] <= alarm_hit | (status_r[ST_ALR] & ~clr_mask[ST_ALR]);
      status_r[ST_OVF] <= (pre_ovf && count_r == '1) | (status_r[ST_OVF] & ~clr_mask[ST_OVF]);
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq                        <= 1'b0;
      external_event_lines_alarm <= 1'b0;
      standby_wake               <= 1'b0;
    end
    else
    begin
      irq                        <= |(status_r & ien_r);
      external_event_lines_alarm <= alarm_hit;
      standby_wake               <= alarm_hit && low_power_state;
    end
  end

  assign bkp.we = wr_acc && bkp_sel;
  assign bkp.addr = BKP_AW'(wb_adr_i - IDX_BKP0);
  assign bkp.wdata = wb_dat_i[BKP_W-1:0];

  always_comb
  begin
    rd_mux = RD_ZERO;
    unique case (wb_adr_i)
      IDX_CTRL:    rd_mux = DATA_W'(ctrl_r);
      IDX_PRELOAD: rd_mux = DATA_W'(preload_r);
      IDX_PREDIV:  rd_mux = DATA_W'(prediv_r);
      IDX_COUNT:   rd_mux = count_r;
      IDX_ALARM:   rd_mux = alarm_r;
      IDX_STATUS:  rd_mux = DATA_W'(status_r);
      IDX_IEN:     rd_mux = DATA_W'(ien_r);
      default:     rd_mux = RD_ZERO;
    endcase
  end

  // backup reads need one extra cycle for the registered memory output
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= '0;
      bkp_pend_r <= 1'b0;
    end
    else
    begin
      wb_ack_o <= 1'b0;
      if (bkp_pend_r)
      begin
        bkp_pend_r <= 1'b0;
        wb_ack_o   <= 1'b1;
        wb_dat_o   <= DATA_W'(bkp.rdata);
      end
      else if (rd_acc && bkp_sel)
        bkp_pend_r <= 1'b1;
      else if (wr_acc || (wb_cyc_i && wb_stb_i && !wb_ack_o))
      begin
        wb_ack_o <= 1'b1;
        wb_dat_o <= wb_we_i ? RD_ZERO : rd_mux;
      end
    end
  end

  property p_alarm_evt;
    @(posedge clock) disable iff (sys_rst)
    alarm_hit |=> external_event_lines_alarm;
  endproperty
  a_alarm_evt: assert property (p_alarm_evt) else $error("alarm event missing");

  property p_cnt_inc;
    @(posedge clock) disable iff (sys_rst)
    pre_ovf && !(wr_acc && wb_adr_i == IDX_COUNT) |=> count_r == $past(count_r) + 1'b1;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not advance");

  property p_irq;
    @(posedge clock) disable iff (sys_rst)
    |(status_r & ien_r) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");

  property p_wake;
    @(posedge clock) disable iff (sys_rst)
    alarm_hit && low_power_state |=> standby_wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no standby wake");

  property p_alarm_flag;
    @(posedge clock) disable iff (sys_rst)
    alarm_hit |=> status_r[ST_ALR];
  endproperty
  a_alarm_flag: assert property (p_alarm_flag) else $error("alarm flag lost");

  property p_sec_flag;
    @(posedge clock) disable iff (sys_rst)
    pre_ovf |=> status_r[ST_SEC];
  endproperty
  a_sec_flag: assert property (p_sec_flag) else $error("periodic flag lost");

  property p_runs_lp;
    @(posedge clock) disable iff (sys_rst)
    low_power_state && ctrl_r[CTRL_EN] && src_tick && prediv_r != '0 && !wr_acc |=> prediv_r == $past(prediv_r) - 1'b1;
  endproperty
  a_runs_lp: assert property (p_runs_lp) else $error("prescaler stalled");

  property p_ovf_reload;
    @(posedge clock) disable iff (sys_rst)
    pre_ovf && !wr_acc |=> prediv_r == $past(preload_r);
  endproperty
  a_ovf_reload: assert property (p_ovf_reload) else $error("prescaler reload wrong");

  property p_ack_drop;
    @(posedge clock) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");

  c_alarm: cover property (@(posedge clock) disable iff (sys_rst) alarm_hit);
  c_irq: cover property (@(posedge clock) disable iff (sys_rst) irq);
  c_bkp_rd: cover property (@(posedge clock) disable iff (sys_rst) bkp_pend_r);
  c_cal: cover property (@(posedge clock) disable iff (sys_rst) $rose(cal_out));
endmodule // rtcb_top

//--- tb/rtcb_top_bench.sv
`timescale 1ns/100ps
module rtcb_top_bench;
  import rtcb_pkg::*;
  logic              clock;
  logic              sys_rst;
  logic              bkp_rst;
  logic [2:0]        tk;
  logic              lp;
  logic              cyc;
  logic              stb;
  logic              we;
  logic [ADDR_W-1:0] adr;
  logic [3:0]        sel;
  logic [DATA_W-1:0] dat;
  logic [DATA_W-1:0] dat_o;
  logic              ack;
  logic              irq;
  logic              alr_ev;
  logic              wake;
  logic              cal_out;
  logic              cal_prev;
  logic [DATA_W-1:0] rd;
  int                miscompares;
  int                samples_checked;
  int                alarm_n;
  int                wake_n;
  int                cal_n;
  int                a0;
  int                w0;
  int                c0;

  rtcb_top u_rtcb_top (
    .clock(clock), .sys_rst(sys_rst), .bkp_rst(bkp_rst),
    .lse_tick(tk[0]), .lsi_tick(tk[1]), .fast_external_osc_tick(tk[2]),
    .low_power_state(lp), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .irq(irq), .external_event_lines_alarm(alr_ev),
    .standby_wake(wake), .cal_out(cal_out)
  );

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // pulse and toggle counters
  always @(posedge clock)
  begin
    cal_prev <= cal_out;
    if (alr_ev === 1'b1) alarm_n <= alarm_n + 1;
    if (wake === 1'b1) wake_n <= wake_n + 1;
    if (cal_out !== cal_prev) cal_n <= cal_n + 1;
  end

  task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wb(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d, input logic [3:0] s);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd = dat_o;
    chk("ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    wb(a, 1'b1, d, 4'hF);
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
    wb(a, 1'b0, 32'h0, 4'hF);
    chk(nm, e, rd);
  endtask

  task automatic ticks(input int src, input int n);
    repeat (n)
    begin
      @(posedge clock);
      tk[src] <= 1'b1;
      @(posedge clock);
      tk[src] <= 1'b0;
      @(posedge clock);
    end
    repeat (3) @(posedge clock);
  endtask

  task automatic give_verdict;
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #2000000;
    miscompares++;
    give_verdict;
  end

  initial
  begin
    {sys_rst, bkp_rst, tk, lp, cyc, stb, we, adr, sel, dat} = '0;
    sys_rst = 1'b1;
    bkp_rst = 1'b1;
    {miscompares, samples_checked, alarm_n, wake_n, cal_n} = '0;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    bkp_rst <= 1'b0;
    rc(IDX_CTRL, {28'h0, CTRL_RST}, "ctrl");
    rc(IDX_PRELOAD, {12'h0, PRELOAD_RST}, "preload");
    rc(IDX_PREDIV, 32'h00007FFF, "prediv");
    rc(IDX_ALARM, 32'hFFFFFFFF, "alarm");
    rc(IDX_COUNT, RD_ZERO, "count");
    rc(IDX_STATUS, RD_ZERO, "status");
    rc(IDX_IEN, RD_ZERO, "ien");
    wr(6'h08, 32'hFFFFFFFF);
    rc(6'h08, RD_ZERO, "unmapped");
    for (int i = 0; i < BKP_N; i++)
      wr(ADDR_W'(IDX_BKP0 + i), 32'hA5A50000 | (i * 32'h1111));
    wb(IDX_BKP0, 1'b1, 32'h0000BEEF, 4'h3);
    wr(IDX_IEN, 32'h7);
    // ordinary reset with standby asserted
    lp <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    lp <= 1'b0;
    rc(IDX_IEN, RD_ZERO, "ien_lost");
    for (int i = 0; i < BKP_N; i++)
      rc(ADDR_W'(IDX_BKP0 + i), i * 32'h1111, "backup");
    wr(IDX_PRELOAD, 32'h3);
    ticks(0, 8);
    rc(IDX_COUNT, 32'h2, "count");
    rc(IDX_PREDIV, 32'h3, "prediv");
    rc(IDX_STATUS, 32'h1, "status");
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(IDX_IEN, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(IDX_CLEAR, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq_off", 32'h0, {31'h0, irq});
    rc(IDX_STATUS, RD_ZERO, "status_clr");
    lp <= 1'b1;
    wr(IDX_CTRL, 32'h5);
    wr(IDX_PRELOAD, 32'h3);
    wr(IDX_COUNT, 32'h0);
    ticks(0, 8);
    ticks(1, 4);
    rc(IDX_COUNT, 32'h1, "count_slow_osc");
    wr(IDX_CTRL, 32'h6);
    ticks(1, 8);
    ticks(2, 512);
    rc(IDX_COUNT, 32'h2, "count_fast_div");
    wr(IDX_CTRL, 32'h7);
    ticks(0, 4);
    ticks(2, 512);
    rc(IDX_COUNT, 32'h2, "count_off");
    wr(IDX_CTRL, 32'h4);
    wr(IDX_PRELOAD, 32'h3);
    wr(IDX_COUNT, 32'h0);
    wr(IDX_ALARM, 32'h1);
    wr(IDX_IEN, 32'h2);
    wr(IDX_CLEAR, 32'h7);
    a0 = alarm_n;
    w0 = wake_n;
    ticks(0, 4);
    rc(IDX_STATUS, 32'h3, "status_alarm");
    chk("irq_alarm", 32'h1, {31'h0, irq});
    chk("event_line", 32'h1, alarm_n - a0);
    chk("wake", 32'h1, wake_n - w0);
    wr(IDX_COUNT, 32'hFFFFFFFF);
    wr(IDX_CLEAR, 32'h7);
    ticks(0, 4);
    rc(IDX_COUNT, RD_ZERO, "count_wrap");
    rc(IDX_STATUS, 32'h5, "status_ovf");
    chk("no_alarm", 32'h1, alarm_n - a0);
    lp <= 1'b0;
    ticks(0, 4);
    chk("event_run", 32'h2, alarm_n - a0);
    chk("no_wake", 32'h1, wake_n - w0);
    wr(IDX_CTRL, 32'hC);
    repeat (4) @(posedge clock);
    c0 = cal_n;
    ticks(0, 128);
    chk("cal_edges", 32'h4, cal_n - c0);
    wr(IDX_CTRL, 32'h4);
    repeat (4) @(posedge clock);
    c0 = cal_n;
    ticks(0, 128);
    chk("cal_idle", 32'h0, cal_n - c0);
    give_verdict;
  end
endmodule // rtcb_top_bench
